// ---- core/edst_pkg.sv ----
package edst_pkg;

    // Register map and field positions of the status block.
    localparam logic [7:0]  ENABLE_STATE_REPORT_OFS = 8'h9C;
    localparam logic [7:0]  CTRL_OFS                = 8'hA0;
    localparam logic [7:0]  IRQ_STATUS_OFS          = 8'hA4;
    localparam logic [7:0]  IRQ_MASK_OFS            = 8'hA8;
    localparam int          ACTIVE_BIT              = 0;
    localparam int          BUSY_BIT                = 1;
    localparam int          LOST_BIT                = 2;
    localparam logic [31:0] REPORT_RESET            = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_READ           = 32'h0000_0000;

    // Shutdown timing: least time from disable request to going inactive.
    localparam int          CLK_MHZ                 = 200;
    localparam int          SHUTDOWN_NS             = 20;
    localparam int          SHUTDOWN_CYC            =
        (SHUTDOWN_NS * CLK_MHZ + 999) / 1000;

    // Slave activity phases seen from the protocol engine.
    typedef enum logic [3:0] {
        EDST_IDLE = 4'b0001,
        EDST_ADDR = 4'b0010,
        EDST_DATA = 4'b0100,
        EDST_MSTR = 4'b1000
    } edst_phase_e;

    // Bus events reported by the protocol engine, one-cycle pulses.
    typedef struct packed {
        logic addr_start;
        logic addr_match;
        logic is_read;
        logic byte_rx;
        logic stop;
        logic nack_done;
        logic master_act;
    } edst_bus_s;

    // Result of a shutdown, captured together.
    typedef struct packed {
        logic lost;
        logic busy;
    } edst_result_s;

endpackage : edst_pkg

// ---- core/edst_avs.sv ----
module edst_avs
    import edst_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        nrst,
    // Avalon-MM slave.
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic             waitrequest,
    output logic [31:0]      readdata,
    // Register side.
    input  wire logic [31:0] report,
    input  wire logic        ctrl_on,
    input  wire logic [2:0]  irq_stat,
    input  wire logic [2:0]  irq_mask,
    output logic             wr_ctrl,
    output logic             wr_stat,
    output logic             wr_mask,
    output logic [31:0]      wdata
);

    logic        done_q;
    logic [31:0] rdata_q;
    logic [31:0] rsel;

    // One wait state per access; the answer comes on the second edge.
    assign waitrequest = (read | write) & ~done_q;
    assign wr_ctrl = write & done_q & (address == CTRL_OFS);
    assign wr_stat = write & done_q & (address == IRQ_STATUS_OFS);
    assign wr_mask = write & done_q & (address == IRQ_MASK_OFS);
    assign wdata   = writedata;
    assign readdata = rdata_q;

    // Read selection; the report register ignores writes.
    always_comb begin
        if (address == ENABLE_STATE_REPORT_OFS) begin
            rsel = report;
        end else if (address == CTRL_OFS) begin
            rsel = {31'h0000_0000, ctrl_on};
        end else if (address == IRQ_STATUS_OFS) begin
            rsel = {29'h0000_0000, irq_stat};
        end else if (address == IRQ_MASK_OFS) begin
            rsel = {29'h0000_0000, irq_mask};
        end else begin
            rsel = UNMAPPED_READ;
        end
    end

    // Capture read data during the wait state so it stands at the answer.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            done_q  <= 1'b0;
            rdata_q <= REPORT_RESET;
        end else begin
            done_q  <= (read | write) & ~done_q;
            rdata_q <= rsel;
        end
    end

endmodule : edst_avs

// ---- core/edst_irq.sv ----
module edst_irq
    import edst_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        nrst,
    // Event and software access.
    input  wire logic [2:0]  events,
    input  wire logic        wr_stat,
    input  wire logic        wr_mask,
    input  wire logic [31:0] wdata,
    output logic [2:0]       stat_q,
    output logic [2:0]       mask_q,
    output logic             irq
);

    logic [2:0] stat_d;

    // Set wins over write-one-to-clear so an event is never lost.
    assign stat_d = events |
        (stat_q & ~(wr_stat ? wdata[2:0] : 3'h0));
    assign irq = |(stat_q & mask_q);

    // Sticky status and mask registers.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            stat_q <= 3'h0;
            mask_q <= 3'h0;
        end else begin
            stat_q <= stat_d;
            if (wr_mask) begin
                mask_q <= wdata[2:0];
            end
        end
    end

endmodule : edst_irq

// ---- core/edst_top.sv ----
module edst_top
    import edst_pkg::*;
(
    // Clock and reset.
    input  wire logic        CLK,
    input  wire logic        NRST,
    // Avalon-MM register port.
    input  wire logic [7:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    output logic             AVS_WAITREQUEST,
    output logic [31:0]      AVS_READDATA,
    // Protocol engine events.
    input  wire edst_bus_s   BUS_EV,
    // Controller status.
    output logic             ACTIVE_STATE_OUT,
    output logic             FORCE_NACK,
    output logic             IRQ
);

    logic         on_q;
    logic         on_d;
    logic         active_q;
    logic         active_d;
    logic [7:0]   dly_q;
    logic [7:0]   dly_d;
    edst_phase_e  ph_q;
    edst_phase_e  ph_d;
    logic         rx_seen_q;
    logic         rx_seen_d;
    edst_result_s res_q;
    edst_result_s res_d;
    logic         nack_q;
    logic         nack_d;
    logic         wr_ctrl;
    logic         wr_stat;
    logic         wr_mask;
    logic [31:0]  wdata;
    logic [2:0]   irq_stat;
    logic [2:0]   irq_mask;
    logic [31:0]  report;
    logic         off_req;
    logic         slave_busy;
    logic         bus_quiet;
    logic         fall;
    logic [2:0]   events;

    // True when the written word turns the controller off.
    function automatic logic turns_off(input logic [31:0] w);
        return ~w[ACTIVE_BIT];
    endfunction : turns_off

    // Bus slave front end.
    edst_avs u_avs (
        .clk         (CLK),
        .nrst        (NRST),
        .address     (AVS_ADDRESS),
        .read        (AVS_READ),
        .write       (AVS_WRITE),
        .writedata   (AVS_WRITEDATA),
        .waitrequest (AVS_WAITREQUEST),
        .readdata    (AVS_READDATA),
        .report      (report),
        .ctrl_on     (on_q),
        .irq_stat    (irq_stat),
        .irq_mask    (irq_mask),
        .wr_ctrl     (wr_ctrl),
        .wr_stat     (wr_stat),
        .wr_mask     (wr_mask),
        .wdata       (wdata)
    );

    // Interrupt status: bit0 shutdown done, bit1 busy, bit2 lost.
    edst_irq u_irq (
        .clk     (CLK),
        .nrst    (NRST),
        .events  (events),
        .wr_stat (wr_stat),
        .wr_mask (wr_mask),
        .wdata   (wdata),
        .stat_q  (irq_stat),
        .mask_q  (irq_mask),
        .irq     (IRQ)
    );

    // Control decode and activity classification.
    assign on_d = wr_ctrl ? wdata[ACTIVE_BIT] : on_q;
    assign off_req = wr_ctrl & turns_off(wdata) & on_q;
    assign slave_busy = (ph_q == EDST_ADDR) | (ph_q == EDST_DATA);
    // Shutdown may only complete when no slave transfer is in flight.
    assign bus_quiet = ~slave_busy & ~BUS_EV.addr_start;
    assign fall = active_q & ~active_d;

    // Slave phase tracker driven by engine pulses.
    always_comb begin
        ph_d = ph_q;
        case (ph_q)
            EDST_IDLE: begin
                if (BUS_EV.addr_start) begin
                    ph_d = EDST_ADDR;
                end else if (BUS_EV.master_act) begin
                    ph_d = EDST_MSTR;
                end
            end
            EDST_ADDR: begin
                if (BUS_EV.stop) begin
                    ph_d = EDST_IDLE;
                end else if (BUS_EV.byte_rx) begin
                    ph_d = (BUS_EV.addr_match & ~BUS_EV.is_read)
                         ? EDST_DATA : EDST_IDLE;
                end
            end
            EDST_DATA: begin
                if (BUS_EV.stop | BUS_EV.nack_done) begin
                    ph_d = EDST_IDLE;
                end
            end
            EDST_MSTR: begin
                if (BUS_EV.stop) begin
                    ph_d = EDST_IDLE;
                end
            end
            default: begin
                ph_d = EDST_IDLE;
            end
        endcase
    end

    // Data phase entered with at least one received byte.
    assign rx_seen_d = (ph_q == EDST_DATA) & ~BUS_EV.stop & ~BUS_EV.nack_done
                     ? (rx_seen_q | BUS_EV.byte_rx) : 1'b0;

    // Shutdown counter: inactive only after bus quiet for a while.
    always_comb begin
        dly_d = dly_q;
        active_d = active_q;
        if (on_d) begin
            active_d = 1'b1;
            dly_d = 8'h00;
        end else if (active_q) begin
            if (!bus_quiet) begin
                dly_d = 8'h00;
            end else if (dly_q >= 8'(SHUTDOWN_CYC - 1)) begin
                active_d = 1'b0;
            end else begin
                dly_d = dly_q + 8'h01;
            end
        end
    end

    // Forced NACK while disabled and a slave transfer runs.
    assign nack_d = ~on_q & active_q & slave_busy;

    // Result flags; cleared while enabled, captured during shutdown.
    always_comb begin
        res_d = res_q;
        if (on_d) begin
            res_d = '0;
        end else if (off_req) begin
            res_d.busy = slave_busy;
            res_d.lost = rx_seen_q;
        end else if (active_q & ~on_q) begin
            if (BUS_EV.stop & slave_busy) begin
                res_d.busy = 1'b1;
                res_d.lost = res_q.lost | (ph_q == EDST_DATA);
            end
            if (BUS_EV.byte_rx & (ph_q == EDST_DATA)) begin
                res_d.lost = 1'b1;
            end
        end
    end

    // Report word; flags meaningful once active bit is zero.
    assign report = {29'h0000_0000, res_q.lost & ~on_q,
                     res_q.busy & ~on_q, active_q};
    assign ACTIVE_STATE_OUT = active_q;
    assign FORCE_NACK = nack_q;
    assign events = {fall & res_q.lost, fall & res_q.busy, fall};

    // State registers.
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            on_q      <= 1'b0;
            active_q  <= 1'b0;
            dly_q     <= 8'h00;
            ph_q      <= EDST_IDLE;
            rx_seen_q <= 1'b0;
            res_q     <= '0;
            nack_q    <= 1'b0;
        end else begin
            on_q      <= on_d;
            active_q  <= active_d;
            dly_q     <= dly_d;
            ph_q      <= ph_d;
            rx_seen_q <= rx_seen_d;
            res_q     <= res_d;
            nack_q    <= nack_d;
        end
    end

    // Properties guarding the status behaviour.
    property p_enabled_forces;
        @(posedge CLK) disable iff (!NRST)
        on_q |-> (report[2:0] == 3'b001);
    endproperty
    a_enabled_forces: assert property (p_enabled_forces)
        else $error("Enabled report not 001.");

    property p_mirror;
        @(posedge CLK) disable iff (!NRST)
        report[ACTIVE_BIT] == ACTIVE_STATE_OUT;
    endproperty
    a_mirror: assert property (p_mirror)
        else $error("Active bit differs from output.");

    property p_delay;
        @(posedge CLK) disable iff (!NRST)
        (on_q && $past(on_q) && !on_d) |=> active_q;
    endproperty
    a_delay: assert property (p_delay)
        else $error("Active bit fell without delay.");

    property p_busy_hold;
        @(posedge CLK) disable iff (!NRST)
        (!on_q && slave_busy && active_q) |=> active_q;
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("Went inactive during slave transfer.");

    property p_busy_capture;
        @(posedge CLK) disable iff (!NRST)
        (off_req && !on_d && slave_busy) |=> res_q.busy;
    endproperty
    a_busy_capture: assert property (p_busy_capture)
        else $error("Busy flag not set on busy disable.");

    property p_idle_clear;
        @(posedge CLK) disable iff (!NRST)
        (off_req && ph_q == EDST_IDLE && !BUS_EV.stop) |=> !res_q.busy;
    endproperty
    a_idle_clear: assert property (p_idle_clear)
        else $error("Busy flag set on idle disable.");

    property p_lost_capture;
        @(posedge CLK) disable iff (!NRST)
        (off_req && rx_seen_q) |=> res_q.lost;
    endproperty
    a_lost_capture: assert property (p_lost_capture)
        else $error("Lost flag not set after data.");

    property p_no_data_clear;
        @(posedge CLK) disable iff (!NRST)
        (off_req && !rx_seen_q && ph_q != EDST_DATA) |=> !res_q.lost;
    endproperty
    a_no_data_clear: assert property (p_no_data_clear)
        else $error("Lost flag set without data phase.");

    property p_nack;
        @(posedge CLK) disable iff (!NRST)
        (!on_q && active_q && slave_busy) |=> FORCE_NACK;
    endproperty
    a_nack: assert property (p_nack)
        else $error("No forced NACK while disabled busy.");

    property p_stop_busy;
        @(posedge CLK) disable iff (!NRST)
        (!on_q && active_q && slave_busy && BUS_EV.stop) |=> res_q.busy;
    endproperty
    a_stop_busy: assert property (p_stop_busy)
        else $error("Busy flag not set on STOP while disabled.");

    c_nack: cover property (@(posedge CLK) disable iff (!NRST)
        FORCE_NACK);

    c_shutdown: cover property (@(posedge CLK) disable iff (!NRST)
        fall);
    c_busy: cover property (@(posedge CLK) disable iff (!NRST)
        fall && res_q.busy);
    c_lost: cover property (@(posedge CLK) disable iff (!NRST)
        fall && res_q.lost);

endmodule : edst_top

// ---- bench/edst_master_model.sv ----
// Remote bus master seen through the protocol engine's event pulses.
module edst_master_model
    import edst_pkg::*;
(
    // Clock and reset.
    input  wire logic      clk,
    input  wire logic      nrst,
    // Command from the bench.
    input  wire logic [2:0] op,
    input  wire logic      go,
    // Events towards the design.
    output edst_bus_s      ev
);
    timeunit 1ns;
    timeprecision 1ps;

    edst_bus_s ev_d;

    // Decode one command into a single-cycle event set; quiet otherwise.
    always_comb begin
        ev_d = '0;
        case (op)
            3'd0: ev_d.addr_start = go;
            3'd1: begin
                ev_d.byte_rx    = go;
                ev_d.addr_match = go;
            end
            3'd2: ev_d.byte_rx = go;
            3'd3: ev_d.stop = go;
            3'd4: ev_d.master_act = go;
            default: ev_d.nack_done = go;
        endcase
    end

    // Registered so every pulse lasts exactly one cycle after the command.
    always_ff @(posedge clk) begin
        if (!nrst) ev <= '0;
        else ev <= ev_d;
    end
endmodule : edst_master_model

// ---- bench/edst_top_bench.sv ----
// Register-level checks of the shutdown status block.
module edst_top_bench;
    import edst_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk;
    logic        nrst;
    logic [7:0]  adr;
    logic        rd;
    logic        wr;
    logic [31:0] wdat;
    logic        wreq;
    logic [31:0] rdat;
    edst_bus_s   bus_ev;
    logic        act;
    logic        fnack;
    logic        irq;
    logic [2:0]  op;
    logic        go;
    logic [31:0] v;
    int          err_count;
    int          total_checks;

    edst_top DUT (.CLK(clk), .NRST(nrst), .AVS_ADDRESS(adr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_WAITREQUEST(wreq),
        .AVS_READDATA(rdat), .BUS_EV(bus_ev), .ACTIVE_STATE_OUT(act),
        .FORCE_NACK(fnack), .IRQ(irq));

    edst_master_model u_mst (.clk(clk), .nrst(nrst), .op(op), .go(go),
        .ev(bus_ev));

    // Free-running 200 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk

    // One Avalon access; the request holds until waitrequest samples low.
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        rd   <= ~w;
        wr   <= w;
        adr  <= a;
        wdat <= d;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (wreq === 1'b0) break;
        end
        if (n == 50) begin
            err_count++;
            end_of_test();
        end
        q  = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        // Let one edge pass idle so registered results have settled and a
        // following call never reassigns the strobes in the same step.
        @(posedge clk);
    endtask : acc

    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        acc(1'b1, a, d, q);
    endtask : wr32

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        acc(1'b0, a, 32'h0000_0000, q);
        chk(q, e);
    endtask : rd_chk

    task automatic ev_send(input logic [2:0] c);
        op <= c;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
    endtask : ev_send

    // Waits for the controller to go fully inactive, within a bound.
    task automatic wait_off;
        int n;
        for (n = 0; n < 200; n++) begin
            @(posedge clk);
            if (act === 1'b0) break;
        end
        if (n == 200) begin
            err_count++;
            end_of_test();
        end
    endtask : wait_off

    // Enable, then drive the listed bus events before disabling.
    task automatic shutdown(input logic [2:0] ops[$], input logic [31:0] e);
        wr32(CTRL_OFS, 32'h0000_0001);
        foreach (ops[i]) ev_send(ops[i]);
        rd_chk(ENABLE_STATE_REPORT_OFS, 32'h0000_0001);
        wr32(CTRL_OFS, 32'h0000_0000);
        @(posedge clk);
        chk({31'h0, act}, 32'h0000_0001);
        wait_off();
        rd_chk(ENABLE_STATE_REPORT_OFS, e);
    endtask : shutdown

    initial begin
        nrst = 1'b0;
        adr = 8'h00;
        rd = 1'b0;
        wr = 1'b0;
        wdat = 32'h0000_0000;
        op = 3'd0;
        go = 1'b0;
        err_count = 0;
        total_checks = 0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);

        // Reset values, read-only report and unmapped space.
        rd_chk(ENABLE_STATE_REPORT_OFS, REPORT_RESET);
        wr32(ENABLE_STATE_REPORT_OFS, 32'h0000_0007);
        rd_chk(ENABLE_STATE_REPORT_OFS, REPORT_RESET);
        rd_chk(8'h40, UNMAPPED_READ);
        $display("test reset done");

        // Enabled state shows only the active bit.
        wr32(CTRL_OFS, 32'h0000_0001);
        chk({31'h0, act}, 32'h0000_0001);
        rd_chk(ENABLE_STATE_REPORT_OFS, 32'h0000_0001);
        wr32(CTRL_OFS, 32'h0000_0000);
        wait_off();
        rd_chk(ENABLE_STATE_REPORT_OFS, 32'h0000_0000);
        $display("test idle shutdown done");

        // Master-only activity leaves both flags clear.
        shutdown('{3'd4}, 32'h0000_0000);
        // The master transfer ends with STOP so the tracker returns to idle.
        ev_send(3'd3);
        $display("test master shutdown done");

        // Disable during the address phase: busy but nothing lost.
        wr32(CTRL_OFS, 32'h0000_0001);
        ev_send(3'd0);
        wr32(CTRL_OFS, 32'h0000_0000);
        @(posedge clk);
        chk({31'h0, fnack}, 32'h0000_0001);
        ev_send(3'd3);
        wait_off();
        rd_chk(ENABLE_STATE_REPORT_OFS, 32'h0000_0002);
        $display("test address abort done");

        // Disable in the data phase of a matched receive, then STOP.
        wr32(CTRL_OFS, 32'h0000_0001);
        ev_send(3'd0);
        ev_send(3'd1);
        ev_send(3'd2);
        rd_chk(ENABLE_STATE_REPORT_OFS, 32'h0000_0001);
        wr32(CTRL_OFS, 32'h0000_0000);
        @(posedge clk);
        chk({31'h0, fnack}, 32'h0000_0001);
        chk({31'h0, act}, 32'h0000_0001);
        ev_send(3'd3);
        wait_off();
        rd_chk(ENABLE_STATE_REPORT_OFS, 32'h0000_0006);
        $display("test data abort done");

        // Interrupt: sticky status, mask, clear by writing ones.
        rd_chk(IRQ_STATUS_OFS, 32'h0000_0007);
        chk({31'h0, irq}, 32'h0000_0000);
        wr32(IRQ_MASK_OFS, 32'h0000_0004);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0000_0001);
        wr32(IRQ_STATUS_OFS, 32'h0000_0007);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0000_0000);
        rd_chk(IRQ_STATUS_OFS, 32'h0000_0000);
        $display("test interrupt done");

        // A new idle shutdown clears the earlier loss report.
        shutdown('{3'd5}, 32'h0000_0000);
        $display("test flag refresh done");
        end_of_test();
    end
endmodule : edst_top_bench
